// file: inc/pbt_pkg.sv
// Shared constants and types for the parallel BCD time output block.
package pbt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int PAR_W   = 48;
    localparam int TIME_W  = 42;
    localparam int TOD_W   = 30;
    localparam int MS_W    = 12;
    localparam int LINES   = 4;
    localparam int ANA_N   = 2;
    localparam int FUNC_N  = 18;
    localparam int FSEL_W  = 5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_NS       = 100;
    localparam int MS_TICK_US   = 1000;
    localparam int CYC_PER_MS   = (MS_TICK_US * 1000) / CLK_NS;
    localparam int PPS_HIGH_MS  = 10;
    localparam int MAX_LAG_NS   = 300;
    localparam int MAX_LAG_CYC  = (MAX_LAG_NS / CLK_NS) < 1 ? 1 : (MAX_LAG_NS / CLK_NS);

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_FSEL    = 8'h04;
    localparam logic [7:0]  REG_ASEL    = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0C;
    localparam logic [7:0]  REG_TIME_LO = 8'h10;
    localparam logic [7:0]  REG_TIME_HI = 8'h14;
    localparam logic [31:0] CTRL_MASK   = 32'h000001FF;
    localparam logic [31:0] FSEL_MASK   = 32'h000FFFFF;
    localparam logic [31:0] ASEL_MASK   = 32'h00000003;
    localparam logic [31:0] CTRL_RST    = 32'h00000000;
    localparam logic [31:0] FSEL_RST    = 32'h00000000;
    localparam logic [31:0] ASEL_RST    = 32'h00000000;
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_DIG_LSB  = 1;
    localparam int CTRL_ANA_LSB  = 5;
    localparam int CTRL_SER_LSB  = 7;
    localparam int PAR_ANA_LSB   = 42;
    localparam int PAR_LINE_LSB  = 44;

    // ------------------------------------------------------------------
    // Output functions and shared-line use
    // ------------------------------------------------------------------
    localparam logic [FSEL_W-1:0] FN_FIRST = 5'h01;
    localparam logic [FSEL_W-1:0] FN_LAST  = 5'h12;
    localparam int FN_IDX_KPPS = 10;
    localparam int FN_IDX_PPS  = 17;
    localparam logic [LINES-1:0] SER_DIR_OUT = 4'h5;

    typedef enum logic [1:0] {
        PBT_SER_NONE = 2'b00,
        PBT_SER_TWO  = 2'b01,
        PBT_SER_FOUR = 2'b10
    } pbt_ser_e;

endpackage : pbt_pkg

// file: logic/pbt_pin_mux.sv
// One shared connector line: serial, digital function or idle.
`timescale 1ns/1ns
module pbt_pin_mux (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic [pbt_pkg::FSEL_W-1:0] func_sel,
    input  wire logic [pbt_pkg::FUNC_N-1:0] func_vec,
    input  wire logic                       dig_own,
    input  wire logic                       ser_own,
    input  wire logic                       ser_out_dir,
    input  wire logic                       ser_val,
    output logic                            pin_o,
    output logic                            pin_oe
);
    import pbt_pkg::*;

    logic sel_bit;

    // ------------------------------------------------------------------
    // Function pick
    // ------------------------------------------------------------------
    // Codes outside the valid range drive low rather than a stale function.
    always_comb begin
        sel_bit = 1'b0;
        if (func_sel >= FN_FIRST && func_sel <= FN_LAST) begin
            sel_bit = func_vec[5'(func_sel - FN_FIRST)];
        end
    end

    // ------------------------------------------------------------------
    // Line driver
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else if (ser_own) begin
            pin_oe <= ser_out_dir;
            pin_o  <= ser_out_dir & ser_val;
        end else if (dig_own) begin
            pin_oe <= 1'b1;
            pin_o  <= sel_bit;
        end else begin
            pin_oe <= 1'b0;
            pin_o  <= 1'b0;
        end
    end

endmodule : pbt_pin_mux

// file: logic/pbt_time_out.sv
// Parallel BCD time output, second and kPPS outputs, shared-line allocation.
//
// Behaviour
// - Time-of-year is driven as a parallel BCD word resolving one millisecond.
// - Alternatively a factory-fixed data word of up to 48 bits is driven.
// - A second pulse, high 10 ms, rises with the reference second pulse.
// - A 1 kPPS square wave has rising edges aligned to the reference pulse.
// - Four shared lines act as digital outputs, each picking one of 18 functions.
// - Up to two analog outputs, each picking one of two functions.
// - The shared lines may form a two- or four-line serial port.
// - Any digital output enabled withdraws four bits of the data word.
// - Each analog output occupies one digital line slot.
// - Each analog output removes one data word bit when that word is used.
// - Serial lines are taken from digital, analog and their data word bits.
// - The BCD time bus is 42 bits wide.
// - Time word is UTC or local, following the selected time code base.
// - Millisecond digits read 000 within 300 ns of the second pulse output.
`timescale 1ns/1ns
module pbt_time_out #(
    parameter int unsigned                   P_CYC_PER_MS   = pbt_pkg::CYC_PER_MS,
    parameter logic [pbt_pkg::PAR_W-1:0]     P_FACTORY_WORD = 48'h000000000000
) (
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [31:0]                 wb_dat_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic                        wb_we_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        reference_second_pulse,
    input  wire logic [pbt_pkg::TOD_W-1:0]   tod_utc,
    input  wire logic [pbt_pkg::TOD_W-1:0]   tod_lcl,
    input  wire logic                        time_base_local,
    input  wire logic [pbt_pkg::FUNC_N-1:0]  aux_func_in,
    input  wire logic                        ser_txd,
    input  wire logic                        ser_rts,
    output logic                             ser_rxd,
    output logic                             ser_cts,
    input  wire logic [pbt_pkg::LINES-1:0]   shr_pin_i,
    output logic [pbt_pkg::LINES-1:0]        shr_pin_o,
    output logic [pbt_pkg::LINES-1:0]        shr_pin_oe,
    output logic [pbt_pkg::ANA_N-1:0]        ana_act,
    output logic [pbt_pkg::ANA_N-1:0]        ana_func,
    output logic [pbt_pkg::PAR_W-1:0]        par_word,
    output logic [pbt_pkg::PAR_W-1:0]        par_oe,
    output logic                             pps_out,
    output logic                             kpps_out
);
    import pbt_pkg::*;

    localparam logic [31:0] CYC_LAST = 32'(P_CYC_PER_MS - 1);
    localparam logic [31:0] CYC_HALF = 32'(P_CYC_PER_MS / 2);
    localparam logic [7:0]  PPS_LAST = 8'(PPS_HIGH_MS - 1);
    localparam int          LAG      = MAX_LAG_CYC;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction : wmask

    // Rolls 999 over to 000; the reference pulse reloads it each second.
    function automatic logic [MS_W-1:0] bcd_inc3(input logic [MS_W-1:0] v);
        logic [MS_W-1:0] r;
        r = v;
        if (r[3:0] != 4'h9) begin
            r[3:0] = 4'(r[3:0] + 4'h1);
        end else begin
            r[3:0] = 4'h0;
            if (r[7:4] != 4'h9) begin
                r[7:4] = 4'(r[7:4] + 4'h1);
            end else begin
                r[7:4] = 4'h0;
                r[11:8] = (r[11:8] != 4'h9) ? 4'(r[11:8] + 4'h1) : 4'h0;
            end
        end
        return r;
    endfunction : bcd_inc3

    // ------------------------------------------------------------------
    // Reference pulse synchroniser
    // ------------------------------------------------------------------
    logic [2:0] ref_s_q;
    logic       sec_edge;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ref_s_q <= 3'h0;
        end else begin
            ref_s_q <= {ref_s_q[1:0], reference_second_pulse};
        end
    end

    assign sec_edge = ref_s_q[1] & ~ref_s_q[2];

    // ------------------------------------------------------------------
    // Millisecond prescaler and kPPS
    // ------------------------------------------------------------------
    logic [31:0] pre_q;
    logic        ms_tick;
    logic        kpps_q;

    assign ms_tick = (pre_q == CYC_LAST) & ~sec_edge;

    // The reference edge restarts the phase so every later tick lines up with it.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pre_q  <= 32'h00000000;
            kpps_q <= 1'b0;
        end else if (sec_edge || pre_q == CYC_LAST) begin
            pre_q  <= 32'h00000000;
            kpps_q <= 1'b1;
        end else begin
            pre_q <= 32'(pre_q + 32'h00000001);
            if (pre_q == 32'(CYC_HALF - 32'h00000001)) begin
                kpps_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Second pulse
    // ------------------------------------------------------------------
    logic       pps_q;
    logic [7:0] pps_ms_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pps_q    <= 1'b0;
            pps_ms_q <= 8'h00;
        end else if (sec_edge) begin
            pps_q    <= 1'b1;
            pps_ms_q <= 8'h00;
        end else if (ms_tick && pps_q) begin
            if (pps_ms_q == PPS_LAST) begin
                pps_q <= 1'b0;
            end
            pps_ms_q <= 8'(pps_ms_q + 8'h01);
        end
    end

    // ------------------------------------------------------------------
    // Time word
    // ------------------------------------------------------------------
    logic [TIME_W-1:0] tw_q;
    logic [TIME_W-1:0] tw_d;

    always_comb begin
        tw_d = tw_q;
        if (sec_edge) begin
            tw_d = {(time_base_local ? tod_lcl : tod_utc), 12'h000};
        end else if (ms_tick) begin
            tw_d = {tw_q[TIME_W-1:MS_W], bcd_inc3(tw_q[MS_W-1:0])};
        end
    end

    // One register holds every digit, so the parallel output never shows a torn word.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tw_q <= '0;
        end else begin
            tw_q <= tw_d;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] fsel_q;
    logic [31:0] asel_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdata;
    logic        wr_en;
    logic        mode_data;
    pbt_ser_e    ser_mode;

    assign wr_en     = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign mode_data = ctrl_q[CTRL_MODE_BIT];
    assign ser_mode  = pbt_ser_e'(ctrl_q[CTRL_SER_LSB +: 2]);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            fsel_q <= FSEL_RST;
            asel_q <= ASEL_RST;
        end else if (wr_en) begin
            if (wb_adr_i == REG_CTRL) begin
                ctrl_q <= wmask(ctrl_q, wb_dat_i, wb_sel_i) & CTRL_MASK;
            end
            if (wb_adr_i == REG_FSEL) begin
                fsel_q <= wmask(fsel_q, wb_dat_i, wb_sel_i) & FSEL_MASK;
            end
            if (wb_adr_i == REG_ASEL) begin
                asel_q <= wmask(asel_q, wb_dat_i, wb_sel_i) & ASEL_MASK;
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared-line allocation
    // ------------------------------------------------------------------
    logic [LINES-1:0]  ser_own;
    logic [ANA_N-1:0]  ana_own;
    logic [LINES-1:0]  dig_own;
    logic [PAR_W-1:0]  wd;

    always_comb begin
        case (ser_mode)
            PBT_SER_TWO:  ser_own = 4'h3;
            PBT_SER_FOUR: ser_own = 4'hF;
            PBT_SER_NONE: ser_own = 4'h0;
            default:      ser_own = 4'h0;
        endcase
    end

    // Analog output k sits on line k, so serial wins over it and it wins over digital.
    assign ana_own = ctrl_q[CTRL_ANA_LSB +: ANA_N] & ~ser_own[ANA_N-1:0];
    assign dig_own = ctrl_q[CTRL_DIG_LSB +: LINES] & ~ser_own
                     & ~{2'b00, ana_own};

    always_comb begin
        wd = '0;
        if (mode_data) begin
            wd[PAR_LINE_LSB +: LINES] = {LINES{|dig_own}} | ser_own;
            wd[PAR_ANA_LSB +: ANA_N]  = ana_own;
        end
    end

    // ------------------------------------------------------------------
    // Parallel word
    // ------------------------------------------------------------------
    logic [PAR_W-1:0] par_q;
    logic [PAR_W-1:0] par_oe_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            par_q    <= '0;
            par_oe_q <= '0;
        end else if (mode_data) begin
            par_q    <= P_FACTORY_WORD & ~wd;
            par_oe_q <= ~wd;
        end else begin
            par_q    <= {6'h00, tw_d};
            par_oe_q <= {6'h00, {TIME_W{1'b1}}};
        end
    end

    // ------------------------------------------------------------------
    // Shared lines and serial port
    // ------------------------------------------------------------------
    logic [LINES-1:0]  pin_s1_q;
    logic [LINES-1:0]  pin_s2_q;
    logic [FUNC_N-1:0] func_vec;
    logic [LINES-1:0]  ser_val;
    logic [ANA_N-1:0]  ana_act_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pin_s1_q  <= 4'hF;
            pin_s2_q  <= 4'hF;
            ana_act_q <= 2'h0;
        end else begin
            pin_s1_q  <= shr_pin_i;
            pin_s2_q  <= pin_s1_q;
            ana_act_q <= ana_own;
        end
    end

    always_comb begin
        func_vec              = aux_func_in;
        func_vec[FN_IDX_KPPS] = kpps_q;
        func_vec[FN_IDX_PPS]  = pps_q;
    end

    assign ser_val = {1'b0, ser_rts, 1'b0, ser_txd};

    for (genvar i = 0; i < LINES; i++) begin : g_line
        pbt_pin_mux u_mux (
            .core_clk    (core_clk),
            .rst_b       (rst_b),
            .func_sel    (fsel_q[i*FSEL_W +: FSEL_W]),
            .func_vec    (func_vec),
            .dig_own     (dig_own[i]),
            .ser_own     (ser_own[i]),
            .ser_out_dir (SER_DIR_OUT[i]),
            .ser_val     (ser_val[i]),
            .pin_o       (shr_pin_o[i]),
            .pin_oe      (shr_pin_oe[i])
        );
    end

    // Unowned receive lines read as idle mark so the serial port sees no noise.
    assign ser_rxd = ser_own[1] ? pin_s2_q[1] : 1'b1;
    assign ser_cts = ser_own[3] ? pin_s2_q[3] : 1'b1;

    // ------------------------------------------------------------------
    // Bus read and acknowledge
    // ------------------------------------------------------------------
    always_comb begin
        case (wb_adr_i)
            REG_CTRL:    rdata = ctrl_q;
            REG_FSEL:    rdata = fsel_q;
            REG_ASEL:    rdata = asel_q;
            REG_STATUS:  rdata = {20'h00000, kpps_q, pps_q, ser_own, ana_own, dig_own};
            REG_TIME_LO: rdata = tw_q[31:0];
            REG_TIME_HI: rdata = {22'h000000, tw_q[TIME_W-1:32]};
            default:     rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q) begin
                rdat_q <= rdata;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign par_word = par_q;
    assign par_oe   = par_oe_q;
    assign pps_out  = pps_q;
    assign kpps_out = kpps_q;
    assign ana_act  = ana_act_q;
    assign ana_func = asel_q[ANA_N-1:0];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] hi_cnt_q;

    always_ff @(posedge core_clk) begin
        if (!rst_b || !pps_q || sec_edge) begin
            hi_cnt_q <= 32'h00000000;
        end else begin
            hi_cnt_q <= 32'(hi_cnt_q + 32'h00000001);
        end
    end

    sequence s_sec_start;
        sec_edge ##1 (pps_q && kpps_q);
    endsequence

    AST_MS_BCD: assert property (@(posedge core_clk) disable iff (!rst_b)
        tw_q[3:0] <= 4'h9 && tw_q[7:4] <= 4'h9 && tw_q[11:8] <= 4'h9)
        else $error("millisecond digits left BCD range");

    AST_FACTORY_WORD: assert property (@(posedge core_clk) disable iff (!rst_b)
        mode_data && $stable(ctrl_q) |=> par_q == (P_FACTORY_WORD & ~$past(wd)))
        else $error("data word does not match factory content");

    AST_PPS_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(pps_q) && !$past(sec_edge) |->
        $past(hi_cnt_q) == 32'(PPS_HIGH_MS * P_CYC_PER_MS - 1))
        else $error("second pulse width wrong");

    AST_SEC_ALIGN: assert property (@(posedge core_clk) disable iff (!rst_b)
        sec_edge |-> s_sec_start ##0 (pre_q == 32'h00000000))
        else $error("second or kPPS not aligned to reference edge");

    AST_NO_OVERLAP: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((dig_own & {2'b00, ana_own}) == 4'h0) && ((dig_own & ser_own) == 4'h0))
        else $error("shared line owned twice");

    AST_DIG_WITHDRAW: assert property (@(posedge core_clk) disable iff (!rst_b)
        mode_data && (|dig_own) |=> par_oe_q[PAR_LINE_LSB +: LINES] == 4'h0)
        else $error("data bits not withdrawn for digital outputs");

    AST_ANA_WITHDRAW: assert property (@(posedge core_clk) disable iff (!rst_b)
        mode_data && ana_own[0] |=> !par_oe_q[PAR_ANA_LSB] && !par_q[PAR_ANA_LSB])
        else $error("data bit not withdrawn for analog output");

    AST_SER_FOUR: assert property (@(posedge core_clk) disable iff (!rst_b)
        ser_mode == PBT_SER_FOUR |=> shr_pin_oe == SER_DIR_OUT && ana_act_q == 2'h0)
        else $error("four-line serial port not holding all lines");

    AST_BUS_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_b)
        !$past(mode_data) |-> par_q[PAR_W-1:TIME_W] == 6'h00)
        else $error("time bus wider than 42 bits");

    AST_TIME_BASE: assert property (@(posedge core_clk) disable iff (!rst_b)
        sec_edge && time_base_local |=> tw_q[TIME_W-1:MS_W] == $past(tod_lcl))
        else $error("local time not loaded");

    AST_MS_LAG: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(pps_q) && !mode_data && $stable(ctrl_q) |->
        ##[0:LAG] (par_q[MS_W-1:0] == 12'h000))
        else $error("millisecond digits late after second pulse");

    AST_ATOMIC: assert property (@(posedge core_clk) disable iff (!rst_b)
        tw_q != $past(tw_q) |-> $past(sec_edge) || $past(ms_tick))
        else $error("time word changed outside a tick");

endmodule : pbt_time_out

// file: sim/pbt_latch_model.sv
// Partner model: external equipment latching the parallel time word.
`timescale 1ns/1ns
module pbt_latch_model (
    input  wire logic        core_clk,
    input  wire logic        pps_out,
    input  wire logic [47:0] par_word,
    output logic [47:0]      lat_word
);
    logic pps_q = 1'b0;
    // Latches one edge after the second pulse rises, as a slow reader would.
    always @(posedge core_clk) begin
        pps_q <= pps_out;
        if (pps_out && !pps_q) begin
            lat_word <= par_word;
        end
    end
endmodule : pbt_latch_model

// file: sim/parallel_bcd_time_output_bench.sv
// Self-checking bench for the parallel time output block.
`timescale 1ns/1ns
module parallel_bcd_time_output_bench;
    import pbt_pkg::*;
    localparam int          CPM = 20;
    localparam logic [47:0] FW  = 48'hFEDCBA987654;
    localparam logic [29:0] UTC = {10'h365, 6'h23, 7'h59, 7'h58};
    localparam logic [29:0] LCL = {10'h364, 6'h19, 7'h59, 7'h58};
    logic        core_clk = 0, rst_b = 0, we = 0, cyc = 0, stb = 0, ref_p = 0, loc = 0;
    logic        txd = 1, ack, pps, kpps, rxd, cts;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [17:0] aux = 18'h0;
    logic [3:0]  pin_o, pin_oe, pin_i = 4'hF;
    logic [1:0]  aact, afn;
    logic [47:0] pw, poe, lat;
    logic [31:0] cfg [4] = '{32'h3, 32'h61, 32'h7F, 32'h101};
    logic [47:0] eoe [4] = '{48'h0FFFFFFFFFFF, 48'hF3FFFFFFFFFF, 48'h03FFFFFFFFFF,
                             48'h0FFFFFFFFFFF};
    int          n_fail = 0, cmp_count = 0, i, n;

    always #50 core_clk = ~core_clk;

    pbt_time_out #(.P_CYC_PER_MS(CPM), .P_FACTORY_WORD(FW)) pbt_time_out_inst (
        .core_clk(core_clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .reference_second_pulse(ref_p), .tod_utc(UTC), .tod_lcl(LCL),
        .time_base_local(loc), .aux_func_in(aux), .ser_txd(txd), .ser_rts(1'b0),
        .ser_rxd(rxd), .ser_cts(cts), .shr_pin_i(pin_i), .shr_pin_o(pin_o), .shr_pin_oe(pin_oe),
        .ana_act(aact), .ana_func(afn), .par_word(pw), .par_oe(poe), .pps_out(pps),
        .kpps_out(kpps));

    pbt_latch_model pbt_latch_model_inst (
        .core_clk(core_clk), .pps_out(pps), .par_word(pw), .lat_word(lat));

    task chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until ack is seen at an edge; the watchdog ends a hang.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task wt(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask : wt

    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        #(5000 * 100);
        n_fail++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        wb(0, REG_CTRL, 32'h0);
        chk(rdat, CTRL_RST);
        wb(0, 8'h20, 32'h0);
        chk(rdat, 48'h0);
        // Only the two low function bits of the analog select register exist.
        wb(1, REG_ASEL, 32'h6);
        wb(0, REG_ASEL, 32'h0);
        chk({rdat, afn}, {32'h2, 2'h2});
        wt(2);
        chk(poe, 48'h03FFFFFFFFFF);
        $display("register test done");
        for (i = 0; i < 2; i++) begin
            @(posedge core_clk);
            loc <= i[0];
            ref_p <= 1'b1;
            for (n = 0; n < 20 && pps !== 1'b1; n++) wt(1);
            chk(pw[41:0], {(i == 1) ? LCL : UTC, 12'h000});
            chk(kpps, 1'b1);
            wt(CPM / 2);
            chk(kpps, 1'b0);
            wt(CPM / 2);
            chk({kpps, pw[11:0]}, 13'h1001);
            chk(lat[41:0], {(i == 1) ? LCL : UTC, 12'h000});
            for (n = CPM; pps === 1'b1 && n < 300; n++) wt(1);
            chk(n, 10 * CPM);
            @(posedge core_clk);
            ref_p <= 1'b0;
            wt(3);
        end
        $display("time word test done");
        // Each shared-line mix is checked against the withdrawn word bits.
        for (i = 0; i < 4; i++) begin
            wb(1, REG_CTRL, cfg[i]);
            wt(2);
            chk(poe, eoe[i]);
            chk(pw, FW & eoe[i]);
            if (i == 2) begin
                wb(0, REG_STATUS, 32'h0);
                chk(rdat[5:0], 6'h3C);
                chk(aact, 2'b11);
            end
        end
        chk({pin_oe, pin_o}, {SER_DIR_OUT, 4'h1});
        @(posedge core_clk);
        pin_i <= 4'h5;
        wt(3);
        chk({rxd, cts}, 2'b00);
        $display("shared line test done");
        wb(1, REG_FSEL, 32'h8000);
        wb(1, REG_CTRL, 32'h10);
        @(posedge core_clk);
        aux <= 18'h1;
        wt(3);
        chk({pin_oe[3], pin_o[3]}, 2'b11);
        @(posedge core_clk);
        aux <= 18'h0;
        wt(3);
        chk(pin_o[3], 1'b0);
        chk({rxd, cts}, 2'b11);
        // Code 18 follows the block's own second pulse, idle here, not the auxiliary input.
        wb(1, REG_FSEL, 32'h90000);
        @(posedge core_clk);
        aux <= 18'h3FFFF;
        wt(3);
        chk({pin_oe[3], pin_o[3]}, 2'b10);
        $display("digital output test done");
        summarize();
    end
endmodule : parallel_bcd_time_output_bench
